// *** acp_aux_control.sv ***
// Auxiliary control register with soft reset and dual data pointer steering
`timescale 1ns/10ps
`default_nettype none
module acp_aux_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire acp_pkg::acp_apb_req_s apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire acp_pkg::acp_op_s coreOp,
  output logic opReady,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic memIsData,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  output logic [7:0] accOut,
  output logic accValid,
  output logic [15:0] jumpTarget,
  output logic jumpValid,
  input wire logic keypadSet,
  output logic softResetReq,
  output logic [15:0] restartAddr,
  output logic brownoutDetectOff,
  output logic brownoutIrqMode,
  output logic lowPowerNvm,
  output logic activePointerSel
);

  acp_pkg::acp_state_s state_ff;
  acp_pkg::acp_state_s nxt_state;
  acp_pkg::acp_ptr_cmd_s ptrCmd [2];
  logic [15:0] ptrValue [2];
  logic [15:0] selPtr;
  logic [7:0] auxRead;
  logic busSetup;
  logic busWrite;
  logic wrAux;
  logic wrLow;
  logic wrHigh;
  logic opFire;
  logic resetNow;
  logic [15:0] accPlusPtr;

  // Two pointer pairs; only the selected one sees inc, load and byte writes, both see clear
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_pair
    acp_ptr_pair u_pair (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ptrCmd(ptrCmd[gi]),
      .ptrValue(ptrValue[gi])
    );
  end

  // Bus phase decode; writes land on the access edge, pready is always high
  assign busSetup = apbReq.psel & ~apbReq.penable;
  assign busWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign wrAux = busWrite & (apbReq.paddr == acp_pkg::AUX_ADDR);
  assign wrLow = busWrite & (apbReq.paddr == acp_pkg::PLO_ADDR);
  assign wrHigh = busWrite & (apbReq.paddr == acp_pkg::PHI_ADDR);
  assign resetNow = state_ff.aux.softResetBit;

  // Selected pair seen by everything else
  assign selPtr = state_ff.aux.pointerSelect ? ptrValue[1] : ptrValue[0];
  assign accPlusPtr = selPtr + {8'h00, coreOp.acc};

  // Readback: bits 2 and 1 are never stored so they read zero
  assign auxRead = {state_ff.aux.keypadFlag, state_ff.aux.brownoutOff,
                    state_ff.aux.brownoutIrqMode, state_ff.aux.lowPowerNvm,
                    state_ff.aux.softResetBit, 1'b0, 1'b0,
                    state_ff.aux.pointerSelect};

  // Core ops stall while a bus write or a soft reset is under way
  assign opReady = ~resetNow & ~busWrite;
  assign opFire = coreOp.valid & opReady;

  // Per-pair commands, all but clear gated by the select
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      ptrCmd[i].clear = resetNow;
      ptrCmd[i].inc = 1'b0;
      ptrCmd[i].load = 1'b0;
      ptrCmd[i].loadVal = coreOp.imm;
      ptrCmd[i].wrLow = 1'b0;
      ptrCmd[i].wrHigh = 1'b0;
      ptrCmd[i].byteVal = apbReq.pwdata[7:0];
      if (state_ff.aux.pointerSelect == i[0] && !resetNow)
      begin
        ptrCmd[i].inc = opFire & (coreOp.code == acp_pkg::OP_PTR_INC);
        ptrCmd[i].load = opFire & (coreOp.code == acp_pkg::OP_PTR_LOAD);
        ptrCmd[i].wrLow = wrLow;
        ptrCmd[i].wrHigh = wrHigh;
      end
    end
  end

  // Next-state logic for register, bus answer and core side
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.memRead = 1'b0;
    nxt_state.memWrite = 1'b0;
    nxt_state.accValid = 1'b0;
    nxt_state.jumpValid = 1'b0;
    nxt_state.readPending = 1'b0;

    // Read data and error are registered in setup so prdata comes from a flop
    if (busSetup)
    begin
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = acp_pkg::RDATA_RESET;
      unique case (apbReq.paddr)
        acp_pkg::AUX_ADDR: nxt_state.prdata = {24'h00_0000, auxRead};
        acp_pkg::PLO_ADDR: nxt_state.prdata = {24'h00_0000, selPtr[7:0]};
        acp_pkg::PHI_ADDR: nxt_state.prdata = {24'h00_0000, selPtr[15:8]};
        default: nxt_state.pslverr = 1'b1;
      endcase
    end

    // Software writes; bits 2 and 1 simply have no home
    if (wrAux)
    begin
      nxt_state.aux.keypadFlag = apbReq.pwdata[acp_pkg::KEYPAD_BIT];
      nxt_state.aux.brownoutOff = apbReq.pwdata[acp_pkg::BOFF_BIT];
      nxt_state.aux.brownoutIrqMode = apbReq.pwdata[acp_pkg::BIRQ_BIT];
      nxt_state.aux.lowPowerNvm = apbReq.pwdata[acp_pkg::LPNVM_BIT];
      nxt_state.aux.softResetBit = apbReq.pwdata[acp_pkg::SOFTRST_BIT];
      nxt_state.aux.pointerSelect = apbReq.pwdata[acp_pkg::SEL_BIT];
    end

    // Register increment: only the select in bit 0 toggles; the carry into bit 1 is dropped
    if (opFire && coreOp.code == acp_pkg::OP_AUX_INC)
    begin
      nxt_state.aux.pointerSelect = ~state_ff.aux.pointerSelect;
    end

    // Indirect jump target
    if (opFire && coreOp.code == acp_pkg::OP_IND_JUMP)
    begin
      nxt_state.jumpTarget = accPlusPtr;
      nxt_state.jumpValid = 1'b1;
    end

    // Code byte fetch at accumulator plus pointer
    if (opFire && coreOp.code == acp_pkg::OP_CODE_READ)
    begin
      nxt_state.memAddr = accPlusPtr;
      nxt_state.memIsData = 1'b0;
      nxt_state.memRead = 1'b1;
      nxt_state.readPending = 1'b1;
    end

    // Data-space moves reach configuration bytes through the pointer
    if (opFire && coreOp.code == acp_pkg::OP_DATA_READ)
    begin
      nxt_state.memAddr = selPtr;
      nxt_state.memIsData = 1'b1;
      nxt_state.memRead = 1'b1;
      nxt_state.readPending = 1'b1;
    end
    if (opFire && coreOp.code == acp_pkg::OP_DATA_WRITE)
    begin
      nxt_state.memAddr = selPtr;
      nxt_state.memIsData = 1'b1;
      nxt_state.memWdata = coreOp.acc;
      nxt_state.memWrite = 1'b1;
    end

    // Memory answers in the strobe cycle; byte goes to accumulator
    if (state_ff.readPending)
    begin
      nxt_state.accOut = memRdata;
      nxt_state.accValid = 1'b1;
    end

    // Keypad event beats a software clear in the same cycle
    if (keypadSet)
    begin
      nxt_state.aux.keypadFlag = 1'b1;
    end

    // Soft reset: one cycle after the write, all state returns to reset
    // values, including the soft-reset bit itself
    if (resetNow)
    begin
      nxt_state = acp_pkg::STATE_RESET;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= acp_pkg::STATE_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs; the soft-reset bit itself is the one-cycle reset request
  assign pready = 1'b1;
  assign prdata = state_ff.prdata;
  assign pslverr = state_ff.pslverr;
  assign memAddr = state_ff.memAddr;
  assign memRead = state_ff.memRead;
  assign memWrite = state_ff.memWrite;
  assign memIsData = state_ff.memIsData;
  assign memWdata = state_ff.memWdata;
  assign accOut = state_ff.accOut;
  assign accValid = state_ff.accValid;
  assign jumpTarget = state_ff.jumpTarget;
  assign jumpValid = state_ff.jumpValid;
  assign softResetReq = state_ff.aux.softResetBit;
  assign restartAddr = acp_pkg::RESTART_VECTOR;
  assign brownoutDetectOff = state_ff.aux.brownoutOff;
  assign brownoutIrqMode = state_ff.aux.brownoutIrqMode;
  assign lowPowerNvm = state_ff.aux.lowPowerNvm;
  assign activePointerSel = state_ff.aux.pointerSelect;

endmodule
`default_nettype wire

// *** acp_aux_control_asserts.sv ***
// Port checks for the auxiliary control block
`timescale 1ns/10ps
`default_nettype none
module acp_aux_control_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire acp_pkg::acp_apb_req_s apbReq,
  input wire logic [31:0] prdata,
  input wire acp_pkg::acp_op_s coreOp,
  input wire logic opReady,
  input wire logic memRead,
  input wire logic memIsData,
  input wire logic [7:0] memRdata,
  input wire logic [7:0] accOut,
  input wire logic accValid,
  input wire logic jumpValid,
  input wire logic softResetReq,
  input wire logic brownoutDetectOff,
  input wire logic activePointerSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic auxWr;
  logic opGo;
  // Writes in the soft-reset cycle are dropped, so leave them out
  assign auxWr = apbReq.psel && apbReq.penable && apbReq.pwrite
    && apbReq.paddr == acp_pkg::AUX_ADDR && !softResetReq;
  assign opGo = coreOp.valid && opReady;
  a_soft_pulse: assert property (
    auxWr && apbReq.pwdata[acp_pkg::SOFTRST_BIT] |=> softResetReq)
    else $error("soft reset not requested");
  a_soft_clears: assert property (
    softResetReq |=> !softResetReq && !activePointerSel && !brownoutDetectOff)
    else $error("soft reset left state");
  a_sel_write: assert property (
    auxWr && !apbReq.pwdata[acp_pkg::SOFTRST_BIT]
    |=> activePointerSel == $past(apbReq.pwdata[acp_pkg::SEL_BIT]))
    else $error("select not written");
  a_boff_write: assert property (
    auxWr && !apbReq.pwdata[acp_pkg::SOFTRST_BIT]
    |=> brownoutDetectOff == $past(apbReq.pwdata[acp_pkg::BOFF_BIT]))
    else $error("brownout off not written");
  a_aux_toggle: assert property (
    opGo && coreOp.code == acp_pkg::OP_AUX_INC
    |=> activePointerSel != $past(activePointerSel) && $stable(brownoutDetectOff))
    else $error("increment did not toggle select");
  a_jump_time: assert property (
    opGo && coreOp.code == acp_pkg::OP_IND_JUMP |=> jumpValid)
    else $error("jump late");
  a_code_fetch: assert property (
    opGo && coreOp.code == acp_pkg::OP_CODE_READ |=> memRead && !memIsData ##1 accValid)
    else $error("code read sequence wrong");
  a_data_move: assert property (
    opGo && coreOp.code == acp_pkg::OP_DATA_READ |=> memRead && memIsData)
    else $error("data read not issued");
  a_acc_load: assert property (
    memRead && !softResetReq |=> accValid && accOut == $past(memRdata))
    else $error("read byte lost");
  a_bit2_zero: assert property (
    apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == acp_pkg::AUX_ADDR
    |-> prdata[2:1] == 2'b00)
    else $error("fixed bits not zero");
  c_soft: cover property (softResetReq);
  c_toggle: cover property (opGo && coreOp.code == acp_pkg::OP_AUX_INC);
  c_acc: cover property (accValid);
endmodule
bind acp_aux_control acp_aux_control_asserts u_acp_aux_control_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
  .apbReq(apbReq), .prdata(prdata), .coreOp(coreOp), .opReady(opReady), .memRead(memRead),
  .memIsData(memIsData), .memRdata(memRdata), .accOut(accOut), .accValid(accValid),
  .jumpValid(jumpValid), .softResetReq(softResetReq), .brownoutDetectOff(brownoutDetectOff),
  .activePointerSel(activePointerSel));
`default_nettype wire

// *** acp_aux_control_test.sv ***
// Self-checking bench for the auxiliary control block
`timescale 1ns/10ps
`default_nettype none
module acp_aux_control_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  acp_pkg::acp_apb_req_s apbReq = '0;
  acp_pkg::acp_op_s coreOp = '0;
  logic keypadSet = 1'b0;
  logic pready, pslverr, opReady, memRead, memWrite, memIsData, accValid, jumpValid;
  logic softResetReq, brownoutDetectOff, brownoutIrqMode, lowPowerNvm, activePointerSel;
  logic [31:0] prdata;
  logic [31:0] rdVal;
  logic [15:0] memAddr, jumpTarget, restartAddr;
  logic [7:0] memWdata, memRdata, accOut;
  int errTotal = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  acp_aux_control u_acp_aux_control (.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .coreOp(coreOp), .opReady(opReady),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memIsData(memIsData),
    .memWdata(memWdata), .memRdata(memRdata), .accOut(accOut), .accValid(accValid),
    .jumpTarget(jumpTarget), .jumpValid(jumpValid), .keypadSet(keypadSet),
    .softResetReq(softResetReq), .restartAddr(restartAddr), .brownoutDetectOff(brownoutDetectOff),
    .brownoutIrqMode(brownoutIrqMode), .lowPowerNvm(lowPowerNvm), .activePointerSel(activePointerSel));
  acp_mem_model u_acp_mem_model (.sys_clk(sys_clk), .rst_n(rst_n), .memAddr(memAddr),
    .memRead(memRead), .memIsData(memIsData), .memRdata(memRdata));
  task automatic wrap_up();
    $display("Mismatches %0d in %0d compares", errTotal, compares);
    if (errTotal == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the acceptance edge; sampled at negedge to avoid races
  task automatic taken(input logic isOp);
    logic ok;
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(negedge sys_clk);
      ok = isOp ? opReady : pready;
      // Read answer taken with ready, while it still stands
      if (!isOp)
      begin
        rdVal = pslverr ? 32'hDEAD_0000 : prdata;
      end
      @(posedge sys_clk);
      if (ok === 1'b1)
        break;
    end
    if (n == 20)
    begin
      errTotal++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    taken(1'b0);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    #1;
  endtask
  task automatic op(input acp_pkg::acp_op_e code, input logic [15:0] imm, input logic [7:0] acc);
    @(posedge sys_clk);
    coreOp <= '{valid: 1'b1, code: code, imm: imm, acc: acc};
    taken(1'b1);
    coreOp.valid <= 1'b0;
    #1;
  endtask
  // Two pairs loaded, pair 1 stepped, then swapped
  task automatic s_pointers();
    op(acp_pkg::OP_PTR_LOAD, 16'h1234, 8'h00);
    apb(1'b1, acp_pkg::AUX_ADDR, 32'h0000_0001);
    chk(activePointerSel, 32'h0000_0001);
    op(acp_pkg::OP_PTR_LOAD, 16'hABCD, 8'h00);
    op(acp_pkg::OP_PTR_INC, 16'h0000, 8'h00);
    apb(1'b0, acp_pkg::PLO_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_00CE);
    apb(1'b0, acp_pkg::PHI_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_00AB);
    op(acp_pkg::OP_AUX_INC, 16'h0000, 8'h00);
    apb(1'b0, acp_pkg::AUX_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0000);
    apb(1'b0, acp_pkg::PLO_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0034);
    apb(1'b0, acp_pkg::PHI_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0012);
  endtask
  // Reads, jump and data write through pair 0
  task automatic s_memory();
    op(acp_pkg::OP_CODE_READ, 16'h0000, 8'h05);
    chk({memIsData, memAddr}, 32'h0000_1239);
    @(posedge sys_clk);
    #1;
    chk({accValid, accOut}, 32'h0000_012B);
    op(acp_pkg::OP_DATA_READ, 16'h0000, 8'h00);
    @(posedge sys_clk);
    #1;
    chk({accValid, accOut}, 32'h0000_01A6);
    op(acp_pkg::OP_IND_JUMP, 16'h0000, 8'h10);
    chk({jumpValid, jumpTarget}, 32'h0001_1244);
    apb(1'b1, acp_pkg::PLO_ADDR, 32'h0000_0077);
    op(acp_pkg::OP_DATA_WRITE, 16'h0000, 8'h5A);
    chk({memWrite, memAddr, memWdata}, 32'h0112_775A);
  endtask
  // Control bits, fixed zeros and keypad flag
  task automatic s_bits();
    apb(1'b1, acp_pkg::AUX_ADDR, 32'h0000_0077);
    apb(1'b0, acp_pkg::AUX_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0071);
    chk({brownoutDetectOff, brownoutIrqMode, lowPowerNvm}, 32'h0000_0007);
    apb(1'b1, 12'hFFC, 32'h0000_00FF);
    chk(rdVal, 32'hDEAD_0000);
    chk(activePointerSel, 32'h0000_0001);
    apb(1'b1, acp_pkg::AUX_ADDR, 32'h0000_0000);
    chk(brownoutDetectOff, 32'h0000_0000);
    @(posedge sys_clk);
    keypadSet <= 1'b1;
    @(posedge sys_clk);
    keypadSet <= 1'b0;
    apb(1'b0, acp_pkg::AUX_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0080);
  endtask
  // Software reset clears register and both pairs
  task automatic s_soft();
    apb(1'b1, acp_pkg::AUX_ADDR, 32'h0000_0009);
    chk({softResetReq, restartAddr}, 32'h0001_0000);
    @(posedge sys_clk);
    #1;
    chk(softResetReq, 32'h0000_0000);
    apb(1'b0, acp_pkg::AUX_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0000);
    apb(1'b0, acp_pkg::PLO_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0000);
    // Second pair must be cleared as well
    op(acp_pkg::OP_AUX_INC, 16'h0000, 8'h00);
    apb(1'b0, acp_pkg::PHI_ADDR, 32'h0000_0000);
    chk(rdVal, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_pointers();
    s_memory();
    s_bits();
    s_soft();
    wrap_up();
  end
endmodule
`default_nettype wire

// *** acp_mem_model.sv ***
// Behavioural code and data memory on the core side of the block
`timescale 1ns/10ps
`default_nettype none
module acp_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memIsData,
  output logic [7:0] memRdata
);
  logic [7:0] idleFill_ff;
  logic [7:0] readByte;
  // Idle pattern keeps changing, so a late sample never passes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idleFill_ff <= 8'h5A;
    end
    else
    begin
      idleFill_ff <= idleFill_ff + 8'h3D;
    end
  end
  // Byte depends on address and space, answered in the read cycle
  assign readByte = memAddr[7:0] ^ memAddr[15:8] ^ {memIsData, 7'h00};
  assign memRdata = memRead ? readByte : idleFill_ff;
endmodule
`default_nettype wire

// *** acp_pkg.sv ***
// Package of constants and carrier types for the auxiliary control block
package acp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] AUX_IDX = 12'h00A2;
  localparam logic [11:0] PLO_IDX = 12'h0040;
  localparam logic [11:0] PHI_IDX = 12'h0041;
  localparam logic [11:0] AUX_ADDR = {AUX_IDX[9:0], 2'b00};
  localparam logic [11:0] PLO_ADDR = {PLO_IDX[9:0], 2'b00};
  localparam logic [11:0] PHI_ADDR = {PHI_IDX[9:0], 2'b00};

  // Field positions of aux_control
  localparam int KEYPAD_BIT = 7;
  localparam int BOFF_BIT = 6;
  localparam int BIRQ_BIT = 5;
  localparam int LPNVM_BIT = 4;
  localparam int SOFTRST_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam int RSV_BIT = 1;
  localparam int SEL_BIT = 0;

  // Reset values
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] RESTART_VECTOR = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Pointer-based operations issued by the core
  typedef enum logic [2:0] {
    OP_PTR_INC = 3'h0,
    OP_PTR_LOAD = 3'h1,
    OP_IND_JUMP = 3'h2,
    OP_CODE_READ = 3'h3,
    OP_DATA_READ = 3'h4,
    OP_DATA_WRITE = 3'h5,
    OP_AUX_INC = 3'h6
  } acp_op_e;

  typedef struct packed {
    logic valid;
    acp_op_e code;
    logic [15:0] imm;
    logic [7:0] acc;
  } acp_op_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } acp_apb_req_s;

  // Stored bits of aux_control; bits 2 and 1 are not stored
  typedef struct packed {
    logic keypadFlag;
    logic brownoutOff;
    logic brownoutIrqMode;
    logic lowPowerNvm;
    logic softResetBit;
    logic pointerSelect;
  } acp_aux_s;

  typedef struct packed {
    logic clear;
    logic inc;
    logic load;
    logic [15:0] loadVal;
    logic wrLow;
    logic wrHigh;
    logic [7:0] byteVal;
  } acp_ptr_cmd_s;

  typedef struct packed {
    logic [15:0] value;
  } acp_ptr_s;

  typedef struct packed {
    acp_aux_s aux;
    logic [31:0] prdata;
    logic pslverr;
    logic [15:0] memAddr;
    logic [7:0] memWdata;
    logic memRead;
    logic memWrite;
    logic memIsData;
    logic readPending;
    logic [7:0] accOut;
    logic accValid;
    logic [15:0] jumpTarget;
    logic jumpValid;
  } acp_state_s;

  localparam acp_state_s STATE_RESET = '{
    aux: AUX_RESET[5:0],
    prdata: RDATA_RESET,
    pslverr: 1'b0,
    memAddr: PTR_RESET,
    memWdata: AUX_RESET,
    memRead: 1'b0,
    memWrite: 1'b0,
    memIsData: 1'b0,
    readPending: 1'b0,
    accOut: AUX_RESET,
    accValid: 1'b0,
    jumpTarget: PTR_RESET,
    jumpValid: 1'b0
  };

endpackage

// *** acp_ptr_pair.sv ***
// One 16-bit data pointer pair with increment, load and byte writes
`timescale 1ns/10ps
`default_nettype none
module acp_ptr_pair (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire acp_pkg::acp_ptr_cmd_s ptrCmd,
  output logic [15:0] ptrValue
);

  acp_pkg::acp_ptr_s state_ff;
  acp_pkg::acp_ptr_s nxt_state;

  // Commands other than clear arrive gated by the select; idle pair holds its value unless cleared
  always_comb
  begin
    nxt_state = state_ff;
    if (ptrCmd.clear)
    begin
      nxt_state.value = acp_pkg::PTR_RESET;
    end
    else if (ptrCmd.load)
    begin
      nxt_state.value = ptrCmd.loadVal;
    end
    else if (ptrCmd.inc)
    begin
      nxt_state.value = state_ff.value + 16'h0001;
    end
    else
    begin
      if (ptrCmd.wrLow)
      begin
        nxt_state.value[7:0] = ptrCmd.byteVal;
      end
      if (ptrCmd.wrHigh)
      begin
        nxt_state.value[15:8] = ptrCmd.byteVal;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '{value: acp_pkg::PTR_RESET};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign ptrValue = state_ff.value;

endmodule
`default_nettype wire
